/* rtl/tsqd_pkg.sv */
// Function
// - five-bit step pointer, upper bits read zero
// - pointer and queue read-only while running
// - eight words, odd step high, even low
// - queue contents survive every reset
// - wait options 0-4 select PWM events
// - wait options 7-15 select peripheral events
// - interrupt step raises interrupt 0 to 3
// - trigger step pulses one of 32 outputs
// - reserved commands and options execute as nop
// - PWM wait sources only on motor variants
`default_nettype none
package tsqd_pkg;

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned STEP_W      = 8;
  localparam int unsigned QPTR_W      = 5;
  localparam int unsigned QIDX_W      = 3;
  localparam int unsigned QUE_DEPTH   = 8;
  localparam int unsigned OPT_W       = 4;
  localparam int unsigned TOPT_W      = 5;
  localparam int unsigned N_EVENTS    = 16;
  localparam int unsigned N_TRIG      = 32;
  localparam int unsigned N_IRQ       = 4;
  localparam int unsigned CTRL_W      = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_QPTR     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_QUE_BASE = 8'h20;
  localparam int unsigned       QUE_PAGE_LSB = 5;
  localparam logic [2:0]        QUE_PAGE     = 3'h1;
  localparam int unsigned       QIDX_LSB     = 2;

  // field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam int unsigned STAT_RUN_BIT   = 0;
  localparam int unsigned STAT_WAIT_BIT  = 1;

  // reset values and unit constants
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
  localparam logic [QPTR_W-1:0] QPTR_RST = 5'h00;
  localparam logic [N_IRQ-1:0]  MASK_RST = 4'h0;
  localparam logic [QPTR_W-1:0] QPTR_ONE = 5'h01;
  localparam logic [N_TRIG-1:0] TRIG_ONE = 32'h0000_0001;
  localparam logic [N_IRQ-1:0]  IRQ_ONE  = 4'h1;

  // step command encoding: upper nibble command, lower nibble option; trigger uses upper three bits, lower five option
  localparam logic [3:0] CMD_WAIT_HI  = 4'h4;
  localparam logic [3:0] CMD_WAIT_LO  = 4'h5;
  localparam logic [3:0] CMD_IRQ      = 4'h7;
  localparam logic [2:0] CMD_TRIG     = 3'h4;
  localparam logic [3:0] OPT_PWM_LAST = 4'h4;
  localparam logic [3:0] OPT_RSV_A    = 4'h5;
  localparam logic [3:0] OPT_RSV_B    = 4'h6;
  localparam logic [3:0] OPT_IRQ_LAST = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_EXEC  = 3'b100
  } tsqd_state_t;

endpackage
`default_nettype wire

/* rtl/tsqd_mem_if.sv */
`default_nettype none
interface tsqd_mem_if;
  import tsqd_pkg::*;
  logic                wr_en;
  logic [QIDX_W-1:0]   wr_idx;
  logic [WORD_W-1:0]   wr_data;
  logic [QIDX_W-1:0]   rd_idx_a;
  logic [WORD_W-1:0]   rd_data_a;
  logic [QIDX_W-1:0]   rd_idx_b;
  logic [WORD_W-1:0]   rd_data_b;

  modport ctl (output wr_en, wr_idx, wr_data, rd_idx_a, rd_idx_b, input rd_data_a, rd_data_b);
  modport mem (input wr_en, wr_idx, wr_data, rd_idx_a, rd_idx_b, output rd_data_a, rd_data_b);
endinterface
`default_nettype wire

/* rtl/tsqd_queue_mem.sv */
`default_nettype none
module tsqd_queue_mem (
  input  wire logic  pclk,   // sequencer clock
  tsqd_mem_if.mem    qif     // queue access port
);
  import tsqd_pkg::*;

  logic [WORD_W-1:0] mem_q [QUE_DEPTH];

  // no reset on purpose: step bytes must survive any reset
  always_ff @(posedge pclk) begin
    if (qif.wr_en) begin
      mem_q[qif.wr_idx] <= qif.wr_data;
    end
  end

  always_ff @(posedge pclk) begin
    qif.rd_data_a <= mem_q[qif.rd_idx_a];
    qif.rd_data_b <= mem_q[qif.rd_idx_b];
  end
endmodule // tsqd_queue_mem
`default_nettype wire

/* rtl/tsqd_top.sv */
`default_nettype none
module tsqd_top #(
  parameter bit HAS_MC_PWM = 1'b1                        // motor-control pwm sources present
) (
  input  wire logic                           pclk,      // sequencer clock
  input  wire logic                           presetn,   // async reset, active low
  input  wire logic                           psel,      // apb select
  input  wire logic                           penable,   // apb enable
  input  wire logic                           pwrite,    // apb direction
  input  wire logic [tsqd_pkg::ADDR_W-1:0]    paddr,     // apb byte address
  input  wire logic [tsqd_pkg::DATA_W-1:0]    pwdata,    // apb write data
  output var  logic [tsqd_pkg::DATA_W-1:0]    prdata,    // apb read data
  output var  logic                           pready,    // apb ready
  output var  logic                           pslverr,   // apb error, unmapped address
  input  wire logic [tsqd_pkg::N_EVENTS-1:0]  event_in,  // peripheral trigger events
  output var  logic [tsqd_pkg::N_TRIG-1:0]    trig_out,  // trigger output line pulses
  output var  logic [tsqd_pkg::N_IRQ-1:0]     seq_irq,   // sequencer interrupt pulses
  output var  logic                           irq        // masked interrupt level
);
  import tsqd_pkg::*;

  tsqd_mem_if qif ();

  tsqd_queue_mem u_mem (
    .pclk (pclk),
    .qif  (qif.mem)
  );

  tsqd_state_t         state_q, state_d;
  logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
  logic [QPTR_W-1:0]   qptr_q, qptr_d;
  logic [N_IRQ-1:0]    mask_q, mask_d;
  logic [N_IRQ-1:0]    istat_q, istat_d;
  logic [DATA_W-1:0]   prdata_q, prdata_d;
  logic                pready_q, pslverr_q, pslverr_d;
  logic [N_TRIG-1:0]   trig_q, trig_d;
  logic [N_IRQ-1:0]    sirq_q, sirq_d;
  logic                irq_q;

  // apb phases: one wait cycle so read data can come from a flop
  wire logic apb_acc     = psel & penable & ~pready_q;
  wire logic apb_done    = psel & penable & pready_q;
  wire logic apb_wr      = apb_done & pwrite;
  wire logic apb_rd_done = apb_done & ~pwrite;

  wire logic hit_ctrl  = (paddr == OFF_CTRL);
  wire logic hit_stat  = (paddr == OFF_STAT);
  wire logic hit_istat = (paddr == OFF_INT_STAT);
  wire logic hit_mask  = (paddr == OFF_INT_MASK);
  wire logic hit_qptr  = (paddr == OFF_QPTR);
  wire logic hit_que   = (paddr[ADDR_W-1:QUE_PAGE_LSB] == QUE_PAGE) & (paddr[QIDX_LSB-1:0] == 2'h0);
  wire logic hit_any   = hit_ctrl | hit_stat | hit_istat | hit_mask | hit_qptr | hit_que;

  wire logic run = ctrl_q[CTRL_EN_BIT] & ctrl_q[CTRL_START_BIT];

  // queue access; software writes are locked out while running
  assign qif.rd_idx_a = paddr[QIDX_LSB +: QIDX_W];
  assign qif.wr_idx   = paddr[QIDX_LSB +: QIDX_W];
  assign qif.wr_data  = pwdata[WORD_W-1:0];
  assign qif.wr_en    = apb_wr & hit_que & ~run;
  // top pointer bit is dropped on purpose: steps 16-31 reuse words 0-7
  assign qif.rd_idx_b = qptr_q[QIDX_W:1];

  // odd step in the upper byte, even step in the lower byte
  wire logic [STEP_W-1:0] cur_step = qptr_q[0] ? qif.rd_data_b[WORD_W-1:STEP_W]
                                               : qif.rd_data_b[STEP_W-1:0];
  wire logic [3:0]        cmd      = cur_step[STEP_W-1:OPT_W];
  wire logic [OPT_W-1:0]  opt      = cur_step[OPT_W-1:0];
  wire logic [TOPT_W-1:0] topt     = cur_step[TOPT_W-1:0];
  wire logic [1:0]        irq_num  = opt[1:0];

  wire logic in_exec  = (state_q == ST_EXEC) & run;
  wire logic is_wait  = (cmd == CMD_WAIT_HI) | (cmd == CMD_WAIT_LO);
  wire logic is_irq   = (cmd == CMD_IRQ);
  wire logic is_trig  = (cur_step[STEP_W-1:TOPT_W] == CMD_TRIG);
  wire logic pwm_opt  = (opt <= OPT_PWM_LAST);
  wire logic rsv_opt  = (opt == OPT_RSV_A) | (opt == OPT_RSV_B);
  // reserved options, and pwm options on variants without pwm, fall through as nop
  wire logic wait_live = is_wait & ~rsv_opt & (~pwm_opt | HAS_MC_PWM);
  wire logic ev        = event_in[opt];
  wire logic wait_met  = (cmd == CMD_WAIT_HI) ? ev : ~ev;
  wire logic step_done = in_exec & (~wait_live | wait_met);
  wire logic waiting   = in_exec & wait_live & ~wait_met;
  wire logic irq_fire  = step_done & is_irq & (opt <= OPT_IRQ_LAST);
  wire logic trig_fire = step_done & is_trig;

  // sequencer: fetch needs one cycle because the queue read is registered
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (run) state_d = ST_FETCH;
      ST_FETCH: state_d = run ? ST_EXEC : ST_IDLE;
      ST_EXEC: begin
        if (!run) state_d = ST_IDLE;
        else if (step_done) state_d = ST_FETCH;
      end
      default:  state_d = ST_IDLE;
    endcase
  end

  always_comb begin
    qptr_d = qptr_q;
    if (step_done) begin
      qptr_d = qptr_q + QPTR_ONE;
    end else if (apb_wr && hit_qptr && !run) begin
      qptr_d = pwdata[QPTR_W-1:0];
    end
  end

  assign ctrl_d    = (apb_wr & hit_ctrl) ? pwdata[CTRL_W-1:0] : ctrl_q;
  assign mask_d    = (apb_wr & hit_mask) ? pwdata[N_IRQ-1:0] : mask_q;
  assign trig_d    = trig_fire ? (TRIG_ONE << topt) : '0;
  assign sirq_d    = irq_fire ? (IRQ_ONE << irq_num) : '0;
  assign pslverr_d = apb_acc & ~hit_any;

  // status read clears; a new event in the same cycle still sets
  genvar gi;
  generate
    for (gi = 0; gi < N_IRQ; gi++) begin : g_istat
      assign istat_d[gi] = sirq_d[gi] | (istat_q[gi] & ~(apb_rd_done & hit_istat));
    end
  endgenerate

  always_comb begin
    prdata_d = '0;
    if (hit_ctrl) begin
      prdata_d[CTRL_W-1:0] = ctrl_q;
    end else if (hit_stat) begin
      prdata_d[STAT_RUN_BIT]  = (state_q != ST_IDLE);
      prdata_d[STAT_WAIT_BIT] = waiting;
      prdata_d[WORD_W-1:STEP_W] = cur_step;
    end else if (hit_istat) begin
      prdata_d[N_IRQ-1:0] = istat_q;
    end else if (hit_mask) begin
      prdata_d[N_IRQ-1:0] = mask_q;
    end else if (hit_qptr) begin
      prdata_d[QPTR_W-1:0] = qptr_q;
    end else if (hit_que) begin
      prdata_d[WORD_W-1:0] = qif.rd_data_a;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      ctrl_q  <= CTRL_RST;
      qptr_q  <= QPTR_RST;
      mask_q  <= MASK_RST;
      istat_q <= '0;
    end else begin
      state_q <= state_d;
      ctrl_q  <= ctrl_d;
      qptr_q  <= qptr_d;
      mask_q  <= mask_d;
      istat_q <= istat_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_acc;
      pslverr_q <= pslverr_d;
      if (apb_acc) prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= '0;
      sirq_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      trig_q <= trig_d;
      sirq_q <= sirq_d;
      irq_q  <= |(istat_q & mask_q);
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign trig_out = trig_q;
  assign seq_irq  = sirq_q;
  assign irq      = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  qptr_upper_zero_a: assert property (
    // read data was latched a cycle earlier, before a step may have moved the pointer
    apb_rd_done & hit_qptr |-> (prdata_q[DATA_W-1:QPTR_W] == '0) && (prdata_q[QPTR_W-1:0] == $past(qptr_q)))
    else $error("pointer readback wrong or upper bits set");

  run_lock_a: assert property (
    run & apb_wr & hit_qptr & ~step_done |=> $stable(qptr_q))
    else $error("pointer written while running");

  que_word_a: assert property (
    apb_rd_done & hit_que |-> prdata_q[DATA_W-1:WORD_W] == '0)
    else $error("queue word upper half not zero");

  wait_met_a: assert property (
    in_exec & wait_live & wait_met |=> (state_q == ST_FETCH) && (qptr_q == $past(qptr_q) + QPTR_ONE))
    else $error("satisfied wait did not complete");

  wait_hold_a: assert property (
    in_exec & wait_live & ~wait_met & run |=> (state_q == ST_EXEC) && $stable(qptr_q))
    else $error("unsatisfied wait did not hold");

  irq_raise_a: assert property (
    in_exec & is_irq & (opt <= OPT_IRQ_LAST) |=> (seq_irq == (IRQ_ONE << $past(irq_num))) && istat_q[$past(irq_num)])
    else $error("interrupt step did not raise its line");

  trig_pulse_a: assert property (
    trig_fire |=> (trig_out == (TRIG_ONE << $past(topt))) ##1 (trig_out == '0))
    else $error("trigger output not a single one-cycle pulse");

  rsv_nop_a: assert property (
    in_exec & is_wait & rsv_opt |=> (state_q == ST_FETCH) && (trig_out == '0) && (seq_irq == '0))
    else $error("reserved wait option did not act as nop");

  pwm_absent_a: assert property (
    !HAS_MC_PWM & in_exec & is_wait & pwm_opt |=> state_q == ST_FETCH)
    else $error("absent pwm source stalled a wait");

  ptr_advance_a: assert property (
    step_done |=> qptr_q == $past(qptr_q) + QPTR_ONE)
    else $error("pointer did not advance after step");

endmodule // tsqd_top
`default_nettype wire

/* test/tsqd_periph_model.sv */
`default_nettype none
module tsqd_periph_model (
  input  wire logic        pclk,     // sequencer clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic [15:0] ev_req,   // events the bench wants raised
  output var  logic [15:0] event_in  // event levels seen by the sequencer
);
  // registered like a real peripheral flag, so a request shows one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) event_in <= 16'h0000;
    else event_in <= ev_req;
  end
endmodule // tsqd_periph_model
`default_nettype wire

/* test/tb_top.sv */
`default_nettype none
module tb_top import tsqd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, trig_out, rd, trig2;
  logic        t31_seen = 1'b0;
  logic        pready, pslverr, irq, er;
  logic [3:0]  seq_irq;
  logic [15:0] ev_req = 16'h0001, event_in;
  logic [15:0] prog [8] = '{0: 16'h7285, 1: 16'h504a, 2: 16'h9f45, default: 16'h0000};
  int          n_errors = 0, cmp_count = 0;

  always #25 pclk = ~pclk;

  tsqd_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                .pslverr, .event_in, .trig_out, .seq_irq, .irq);
  tsqd_periph_model periph (.pclk, .presetn, .ev_req, .event_in);
  // variant without motor pwm shares the bus; its pwm waits must fall through
  tsqd_top #(.HAS_MC_PWM(1'b0)) dut_nopwm (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
                .prdata(), .pready(), .pslverr(), .event_in, .trig_out(trig2), .seq_irq(), .irq());

  always @(posedge pclk) if (trig2[31]) t31_seen <= 1'b1;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic fail();
    n_errors++;
    $display("MISMATCH wait bound expired");
    print_verdict();
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // one transfer, then an idle edge so no strobe is driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) fail();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic wait_pulse(input logic [31:0] et, input logic [3:0] ei);
    int k;
    for (k = 0; k < 100; k++) begin
      @(posedge pclk);
      if (trig_out !== 32'h0 || seq_irq !== 4'h0) break;
    end
    if (k == 100) fail();
    chk("trig_out", trig_out, et);
    chk("seq_irq", {28'h0, seq_irq}, {28'h0, ei});
  endtask

  task automatic wait_step(input logic [7:0] sb);
    int k;
    for (k = 0; k < 50; k++) begin
      apb(1'b0, OFF_STAT, 32'h0);
      if (rd[1] === 1'b1 && rd[15:8] === sb) break;
    end
    if (k == 50) fail();
    chk("status", {22'h0, rd[15:8], rd[1:0]}, {22'h0, sb, 2'h3});
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("qptr", OFF_QPTR, 32'h0);
    rdc("ctrl", OFF_CTRL, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    apb(1'b1, OFF_QPTR, 32'hffff_ffff);
    rdc("qptr", OFF_QPTR, 32'h1f);
    apb(1'b1, OFF_QPTR, 32'h0);
    for (int i = 0; i < 8; i++) apb(1'b1, OFF_QUE_BASE + 8'(4 * i), {16'hffff, prog[i]});
    for (int i = 0; i < 8; i++) rdc("queue", OFF_QUE_BASE + 8'(4 * i), {16'h0, prog[i]});
    $display("test registers done");
    apb(1'b1, OFF_INT_MASK, 32'h4);
    apb(1'b1, OFF_CTRL, 32'h3);
    wait_pulse(32'h0000_0020, 4'h0);
    wait_pulse(32'h0, 4'h4);
    wait_step(8'h4a);
    chk("irq", {31'h0, irq}, 32'h1);
    // writes while parked on a wait must bounce off
    apb(1'b1, OFF_QPTR, 32'h7);
    apb(1'b1, OFF_QUE_BASE, 32'h0);
    rdc("qptr", OFF_QPTR, 32'h2);
    rdc("queue", OFF_QUE_BASE, 32'h7285);
    rdc("int_stat", OFF_INT_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, irq}, 32'h0);
    rdc("int_stat", OFF_INT_STAT, 32'h0);
    ev_req <= 16'h0401;
    wait_step(8'h50);
    repeat (6) @(posedge pclk);
    chk("nopwm_trig31", {31'h0, t31_seen}, 32'h1);
    ev_req <= 16'h0000;
    wait_pulse(32'h8000_0000, 4'h0);
    apb(1'b1, OFF_CTRL, 32'h0);
    $display("test sequence done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("queue", OFF_QUE_BASE + 8'h04, 32'h504a);
    rdc("qptr", OFF_QPTR, 32'h0);
    $display("test reset done");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
